// >>> dbgms_pin.v
/*
 * Shared background-debug / mode-select pin logic.
 * Assumes one 10 MHz debug clock that also clocks the debug controller, a synchronous
 * active-high reset, and an open-drain pin resolved outside from the enable.
 */
// Behaviour
// - During power-on or debug-forced reset the pin is only a mode-select input.
// - Once any reset ends the pin becomes the serial debug line.
// - An undriven, pulled-up pin gives normal mode at the end of the reset.
// - A host holding the pin low at that reset puts the device in background mode.
// - Each bit time on the link lasts sixteen debug clock cycles.
// - The host sizes its bit timing for a debug clock as fast as the bus clock.
// - The line is pseudo open-drain with short driven-high speedup pulses.
`timescale 1ns/1ns
`include "dbgms_map.vh"

module dbgms_pin
(
	// Clock and reset.
	input wire ref_clk,
	input wire sys_rst,
	// Reset causes; mode_reset marks power-on or debug-forced reset.
	input wire mode_reset,
	// Pin, split into level, output and enable.
	input wire debug_mode_select_pin_i,
	output reg debug_mode_select_pin_o,
	output reg debug_mode_select_pin_oe,
	// Mode result.
	output reg debug_serial_pin_mode_r,
	output reg debug_serial_active_r,
	// Debug controller side: one bit per request.
	input wire tx_req,
	input wire tx_bit,
	input wire rx_req,
	output reg busy_r,
	output reg rx_valid_r,
	output reg rx_bit_r
);

////////////////////////////////////////////////////////////////////////////////
// Mode capture.

reg mode_rst_seen_r;
reg ms_level_r;

always @(posedge ref_clk)
begin
	if (sys_rst)
	begin
		debug_serial_active_r <= 1'h0;
		if (mode_reset)
			mode_rst_seen_r <= 1'h1;
		ms_level_r <= debug_mode_select_pin_i;
	end
	else
	begin
		debug_serial_active_r <= 1'h1;
		mode_rst_seen_r <= 1'h0;
	end
end

always @(posedge ref_clk)
begin
	if (!sys_rst && mode_rst_seen_r)
		debug_serial_pin_mode_r <= (ms_level_r != `DBGMS_MS_NORMAL);
	else if (sys_rst && mode_reset)
		debug_serial_pin_mode_r <= 1'h0;
end

////////////////////////////////////////////////////////////////////////////////
// Serial bit engine.

localparam ST_IDLE = 3'h1;
localparam ST_TX = 3'h2;
localparam ST_RX = 3'h4;

reg [2:0] state_r;
reg [2:0] state_nxt;
reg [`DBGMS_CNT_W-1:0] cnt_r;
reg [`DBGMS_CNT_W-1:0] cnt_nxt;
reg bit_r;
reg bit_nxt;
reg busy_nxt;
reg rx_valid_nxt;
reg rx_bit_nxt;
reg pin_o_nxt;
reg pin_oe_nxt;

// Flags the last debug clock cycle of a bit time.
function last_cycle;
	input [`DBGMS_CNT_W-1:0] c;
	begin
		last_cycle = (c == `DBGMS_BIT_CYCLES - `DBGMS_CNT_ONE);
	end
endfunction

// Gives the cycle at which the driven high speedup pulse of a bit starts.
function [`DBGMS_CNT_W-1:0] rise_at;
	input b;
	begin
		if (b)
			rise_at = `DBGMS_ONE_LOW_END;
		else
			rise_at = `DBGMS_LOW_END;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Next-state logic of the bit engine.

always @*
begin
	state_nxt = state_r;
	cnt_nxt = cnt_r;
	bit_nxt = bit_r;
	busy_nxt = busy_r;
	rx_valid_nxt = 1'h0;
	rx_bit_nxt = rx_bit_r;
	pin_o_nxt = debug_mode_select_pin_o;
	pin_oe_nxt = debug_mode_select_pin_oe;
	case (state_r)
		ST_IDLE:
		begin
			cnt_nxt = `DBGMS_CNT_ZERO;
			pin_oe_nxt = 1'h0;
			if (tx_req)
			begin
				state_nxt = ST_TX;
				bit_nxt = tx_bit;
				busy_nxt = 1'h1;
				pin_o_nxt = 1'h0;
				pin_oe_nxt = 1'h1;
			end
			else if (rx_req)
			begin
				state_nxt = ST_RX;
				busy_nxt = 1'h1;
			end
		end
		ST_TX:
		begin
			cnt_nxt = cnt_r + `DBGMS_CNT_ONE;
			if (cnt_r == rise_at(bit_r))
			begin
				pin_o_nxt = 1'h1;
				pin_oe_nxt = 1'h1;
			end
			else if (cnt_r == rise_at(bit_r) + `DBGMS_SPEEDUP)
			begin
				pin_o_nxt = 1'h0;
				pin_oe_nxt = 1'h0;
			end
			if (last_cycle(cnt_r))
			begin
				state_nxt = ST_IDLE;
				busy_nxt = 1'h0;
				pin_oe_nxt = 1'h0;
			end
		end
		ST_RX:
		begin
			cnt_nxt = cnt_r + `DBGMS_CNT_ONE;
			if (cnt_r == `DBGMS_SAMPLE_AT)
				rx_bit_nxt = debug_mode_select_pin_i;
			if (last_cycle(cnt_r))
			begin
				state_nxt = ST_IDLE;
				busy_nxt = 1'h0;
				rx_valid_nxt = 1'h1;
			end
		end
		default:
		begin
			state_nxt = ST_IDLE;
			busy_nxt = 1'h0;
			pin_oe_nxt = 1'h0;
		end
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// Registers of the bit engine.

always @(posedge ref_clk)
begin
	if (sys_rst)
	begin
		state_r <= ST_IDLE;
		cnt_r <= `DBGMS_CNT_ZERO;
		bit_r <= 1'h0;
		busy_r <= 1'h0;
		rx_valid_r <= 1'h0;
		rx_bit_r <= 1'h0;
		debug_mode_select_pin_o <= 1'h0;
		debug_mode_select_pin_oe <= 1'h0;
	end
	else
	begin
		state_r <= state_nxt;
		cnt_r <= cnt_nxt;
		bit_r <= bit_nxt;
		busy_r <= busy_nxt;
		rx_valid_r <= rx_valid_nxt;
		rx_bit_r <= rx_bit_nxt;
		debug_mode_select_pin_o <= pin_o_nxt;
		debug_mode_select_pin_oe <= pin_oe_nxt;
	end
end

endmodule // dbgms_pin

// >>> dbgms_map.vh
/*
 * Constants for the shared debug / mode-select pin logic.
 * Assumes inclusion by the single design file that uses them.
 */
`ifndef DBGMS_MAP_VH
`define DBGMS_MAP_VH

// Debug clock cycles in one bit time on the serial link.
`define DBGMS_BIT_CYCLES 5'h10
// Width of the bit-time counter.
`define DBGMS_CNT_W 5
// Cycle within the bit time at which the device samples the line.
`define DBGMS_SAMPLE_AT 5'h0a
// Cycle within the bit time at which the device releases a driven low.
`define DBGMS_LOW_END 5'h0d
// Length of the actively driven high speedup pulse, in cycles.
`define DBGMS_SPEEDUP 5'h01
// Cycle within the bit time at which a one ends its short low.
`define DBGMS_ONE_LOW_END 5'h00
// Counter start value and counter step.
`define DBGMS_CNT_ZERO 5'h00
`define DBGMS_CNT_ONE 5'h01
// Level of the pin that selects normal mode.
`define DBGMS_MS_NORMAL 1'h1

`endif

// >>> dbgms_props.sv
/* Checker on the pin block ports. Assumes a bind to dbgms_pin. */
`timescale 1ns/1ns
module dbgms_props(input wire ref_clk, sys_rst, mode_reset, debug_mode_select_pin_i,
	debug_mode_select_pin_o, debug_mode_select_pin_oe, debug_serial_pin_mode_r, debug_serial_active_r,
	tx_req, rx_req, busy_r, rx_valid_r);
	wire oe = debug_mode_select_pin_oe, sa = debug_serial_active_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	a_quiet_reset: assert property ($past(sys_rst) |-> !oe && !sa)
		else $error("pin used in reset");
	a_serial_on: assert property ($fell(sys_rst) |=> sa) else $error("no serial");
	a_mode_pick: assert property ($past(sys_rst) && $past(mode_reset) |=>
		debug_serial_pin_mode_r == !$past(debug_mode_select_pin_i, 2)) else $error("bad mode");
	a_mode_hold: assert property (!$past(mode_reset, 2) |-> $stable(debug_serial_pin_mode_r))
		else $error("mode moved");
	a_bit_len: assert property ($rose(busy_r) |-> ##15 busy_r ##1 !busy_r)
		else $error("bit length");
	a_req_take: assert property (!busy_r && (tx_req || rx_req) |=> busy_r)
		else $error("request lost");
	a_rx_pulse: assert property (rx_valid_r |-> $fell(busy_r) ##1 !rx_valid_r)
		else $error("rx pulse");
	a_speedup_short: assert property (oe && debug_mode_select_pin_o |=> !oe)
		else $error("long high drive");
endmodule // dbgms_props
bind dbgms_pin dbgms_props props_u(.*);

// >>> dbgms_host.sv
/* Debug host model. Assumes an open-drain pin with a pullup. */
`timescale 1ns/1ns
module dbgms_host(input wire debug_mode_select_pin_oe, debug_mode_select_pin_o, host_low,
	output wire debug_mode_select_pin_i);
	// The host pulls low on command and the pullup lifts a free line.
	assign debug_mode_select_pin_i = debug_mode_select_pin_oe ?
		debug_mode_select_pin_o : !host_low;
endmodule // dbgms_host

// >>> tb_debug_pin_mode_select.sv
/* Pin block bench. Assumes the host model and the checker. */
`timescale 1ns/1ns
module tb_debug_pin_mode_select;
	reg ref_clk = 0, sys_rst = 1, mode_reset = 1, host_low = 1, tx_req = 0, tx_bit = 0, rx_req = 0;
	wire debug_mode_select_pin_i, debug_mode_select_pin_o, debug_mode_select_pin_oe, debug_serial_pin_mode_r;
	wire debug_serial_active_r, busy_r, rx_valid_r, rx_bit_r;
	integer mismatches = 0, checks = 0, n, i;
	reg [31:0] lf = 32'h19bf39d3;
	dbgms_pin dut_u(.*);
	dbgms_host host_u(.*);
	initial forever #50 ref_clk = ~ref_clk;
	function [31:0] nx(input [31:0] v); nx = {v[30:0], ^(v & 32'h80200003)}; endfunction
	task cmp(input g, input e);
	begin
		checks = checks + 1;
		if (g !== e) begin mismatches = mismatches + 1; $display("[ERR] %0t mismatch", $time); end
	end
	endtask
	task conclude;
	begin
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	end
	endtask
	task rst(input m, input h);
	begin
		@(posedge ref_clk) #1 {sys_rst, mode_reset, host_low} = {1'h1, m, h};
		repeat (5) @(posedge ref_clk);
		#1 cmp(debug_serial_active_r, 0);
		{sys_rst, mode_reset} = 2'h0;
		@(posedge ref_clk) #1 host_low = 0;
		@(posedge ref_clk) #1 cmp(debug_serial_active_r, 1);
	end
	endtask
	task bit_op(input r, input b);
	begin
		{tx_bit, host_low, tx_req, rx_req} = {b, r & !b, !r, r};
		@(posedge ref_clk) #1 {tx_req, rx_req} = 2'h0;
		n = 0;
		while (n < 40 && (n == 0 || busy_r))
		begin
			@(posedge ref_clk) #1 n = n + 1;
			if (!r && busy_r) cmp(debug_mode_select_pin_i, b | (n >= 14));
		end
		cmp(n == 16, 1);
		if (n >= 40) conclude;
		cmp(rx_valid_r, r);
		if (r) cmp(rx_bit_r, b);
	end
	endtask
	initial begin
		rst(1, 1);
		cmp(debug_serial_pin_mode_r, 1);
		rst(1, 0);
		cmp(debug_serial_pin_mode_r, 0);
		for (i = 0; i < 24; i = i + 1) begin lf = nx(lf); bit_op(lf[0], lf[1]); end
		rst(0, 1);
		cmp(debug_serial_pin_mode_r, 0);
		conclude;
	end
endmodule // tb_debug_pin_mode_select
